/* ibaf_filter.sv */
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module ibaf_filter (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	// Register port
	input  wire ibaf_pkg::ibaf_bus_t bus,
	output logic [15:0]            regRdata,
	// Init block fetch
	input  wire logic [23:0]       initBlockBase,
	output logic                   memReq,
	output logic [23:0]            memAddr,
	input  wire logic              memAck,
	input  wire logic [15:0]       memData,
	// Receive address check
	input  wire logic              destValid,
	input  wire logic [47:0]       destAddr,
	input  wire logic [31:0]       destCrc,
	output logic                   frameAccept,
	output logic                   frameReject,
	// Loaded configuration
	output logic [15:0]            modeControl,
	output logic [23:0]            rxRingBase,
	output logic [23:0]            txRingBase,
	output logic                   initDone
);
	ibaf_pkg::ibaf_state_all_t s_q, s_d;

	function automatic logic [15:0] lenDecode(input logic [2:0] code);
		lenDecode = 16'h0001 << code; // see (R4)
	endfunction : lenDecode

	logic        isLogical;
	logic        isBcast;
	logic        hashHit;
	logic        nodeHit;
	logic [5:0]  hashIdx;
	logic [15:0] rdVal;

	always_comb begin
		isLogical = destAddr[0]; // see (R7) (R13) (R14)
		isBcast   = &destAddr;
		hashIdx   = destCrc[31:26]; // see (R8)
		hashHit   = s_q.hash[hashIdx]; // see (R9) (R10)
		nodeHit   = (destAddr == s_q.node); // see (R7)
		unique case (bus.addr)
			ibaf_pkg::REG_MODE:   rdVal = s_q.mode;
			ibaf_pkg::REG_RXCNT:  rdVal = s_q.rxCount;
			ibaf_pkg::REG_TXCNT:  rdVal = s_q.txCount;
			ibaf_pkg::REG_STATUS: rdVal = {14'h0000, s_q.state != ibaf_pkg::ST_IDLE, s_q.initDone};
			default:              rdVal = 16'h0000;
		endcase
	end

	always_comb begin
		s_d        = s_q;
		s_d.accept = 1'b0;
		s_d.reject = 1'b0;
		s_d.rdata  = bus.rd ? rdVal : 16'h0000;
		unique case (s_q.state)
			ibaf_pkg::ST_IDLE: begin
				// Host alignment is trusted; bit 0 is dropped
				if (bus.wr && bus.addr == ibaf_pkg::REG_CTRL && bus.wdata[0]) begin // see (R1)
					s_d.state    = ibaf_pkg::ST_REQ;
					s_d.offset   = ibaf_pkg::WORD_MODE;
					s_d.initDone = 1'b0;
				end
			end
			ibaf_pkg::ST_REQ: begin
				s_d.memReq  = 1'b1;
				s_d.memAddr = {initBlockBase[23:1], 1'b0} + {19'h00000, s_q.offset};
				s_d.state   = ibaf_pkg::ST_WAIT;
			end
			ibaf_pkg::ST_WAIT: begin
				if (memAck) begin
					s_d.memReq = 1'b0;
					// Word offsets walk the block in fetch order
					if (s_q.offset == ibaf_pkg::WORD_MODE)
						s_d.mode = memData; // see (R15)
					else if (s_q.offset < ibaf_pkg::WORD_HASH0)
						s_d.node[(s_q.offset - ibaf_pkg::WORD_NODE0) * 8 +: 16] = memData; // see (R2)
					else if (s_q.offset < ibaf_pkg::WORD_RXLO)
						s_d.hash[(s_q.offset - ibaf_pkg::WORD_HASH0) * 8 +: 16] = memData; // see (R2)
					else if (s_q.offset == ibaf_pkg::WORD_RXLO)
						s_d.rxBase[15:0] = memData;
					else if (s_q.offset == ibaf_pkg::WORD_RXHI) begin
						s_d.rxBase[23:16] = memData[7:0];
						s_d.rxCount = lenDecode(memData[ibaf_pkg::LEN_MSB:ibaf_pkg::LEN_LSB]); // see (R3)
					end else if (s_q.offset == ibaf_pkg::WORD_TXLO)
						s_d.txBase[15:0] = memData;
					else begin
						s_d.txBase[23:16] = memData[7:0];
						s_d.txCount = lenDecode(memData[ibaf_pkg::LEN_MSB:ibaf_pkg::LEN_LSB]); // see (R3)
					end
					if (s_q.offset == ibaf_pkg::WORD_LAST) begin
						s_d.state    = ibaf_pkg::ST_IDLE;
						s_d.initDone = 1'b1;
					end else begin
						s_d.offset = s_q.offset + 5'h02;
						s_d.state  = ibaf_pkg::ST_REQ;
					end
				end
			end
		endcase
		// Ring counts writable only after the block is loaded; see (R5)
		if (bus.wr && s_q.initDone && s_q.state == ibaf_pkg::ST_IDLE) begin
			if (bus.addr == ibaf_pkg::REG_RXCNT)
				s_d.rxCount = bus.wdata;
			if (bus.addr == ibaf_pkg::REG_TXCNT)
				s_d.txCount = bus.wdata;
			if (bus.addr == ibaf_pkg::REG_MODE)
				s_d.mode = bus.wdata;
		end
		// Ring placement and FCS allocation are software's job; see (R6) (R12)
		if (destValid && s_q.initDone) begin
			if (isBcast)
				s_d.accept = !s_q.mode[ibaf_pkg::MODE_DRCVBC] || s_q.mode[ibaf_pkg::MODE_PROM]; // see (R11)
			else if (s_q.mode[ibaf_pkg::MODE_PROM])
				s_d.accept = 1'b1;
			else if (isLogical)
				s_d.accept = hashHit; // see (R8)
			else
				s_d.accept = nodeHit;
			s_d.reject = !s_d.accept;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s_q         <= '0;
			s_q.state   <= ibaf_pkg::ST_IDLE;
			s_q.mode    <= ibaf_pkg::MODE_RESET;
			s_q.rxCount <= ibaf_pkg::COUNT_RESET;
			s_q.txCount <= ibaf_pkg::COUNT_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign regRdata    = s_q.rdata;
	assign memReq      = s_q.memReq;
	assign memAddr     = s_q.memAddr;
	assign frameAccept = s_q.accept;
	assign frameReject = s_q.reject;
	assign modeControl = s_q.mode;
	assign rxRingBase  = s_q.rxBase;
	assign txRingBase  = s_q.txBase;
	assign initDone    = s_q.initDone;
endmodule : ibaf_filter
`default_nettype wire

/* ibaf_filter_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module ibaf_filter_chk (
	input wire logic                core_clk, rst_n, memReq, memAck, destValid,
	input wire logic                frameAccept, frameReject, initDone,
	input wire ibaf_pkg::ibaf_bus_t bus,
	input wire logic [15:0]         regRdata, modeControl,
	input wire logic [47:0]         destAddr
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic dv, bc;
	assign dv = destValid && initDone;
	assign bc = dv && (&destAddr);
	a_one_verdict: assert property (dv |=> frameAccept ^ frameReject) else $error("verdict");
	a_no_verdict: assert property (!dv |=> !frameAccept && !frameReject) else $error("stray");
	a_bc_accept: assert property (bc && (!modeControl[14] || modeControl[15]) |=> frameAccept)
		else $error("bc acc");
	a_bc_reject: assert property (bc && modeControl[14] && !modeControl[15] |=> frameReject)
		else $error("bc rej");
	a_prom_accept: assert property (dv && modeControl[15] |=> frameAccept) else $error("prom");
	a_req_drop: assert property (memReq && memAck |=> !memReq) else $error("req");
	a_done_ack: assert property ($rose(initDone) |-> $past(memAck)) else $error("done");
	a_rd_idle: assert property (!$past(bus.rd) |-> regRdata == 16'h0000) else $error("rdata");
	c_bc_off: cover property (bc && modeControl[14]);
	c_hash_hit: cover property (dv && destAddr[0] && !modeControl[15] ##1 frameAccept);
	c_init: cover property ($rose(initDone));
endmodule : ibaf_filter_chk
bind ibaf_filter ibaf_filter_chk i_ibaf_filter_chk (.core_clk(core_clk), .rst_n(rst_n), .bus(bus),
	.regRdata(regRdata), .memReq(memReq), .memAck(memAck), .destValid(destValid),
	.destAddr(destAddr), .frameAccept(frameAccept), .frameReject(frameReject),
	.modeControl(modeControl), .initDone(initDone));
`default_nettype wire

/* ibaf_filter_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module ibaf_filter_tb;
	logic core_clk = 0, rst_n = 0, destValid = 0, slow = 0, memAck, memReq, initDone, fa, fr, rdSeen = 0;
	ibaf_pkg::ibaf_bus_t bus = '0;
	logic [15:0] regRdata, memData, modeControl, mode;
	logic [23:0] base = 0, memAddr, rxB, txB;
	logic [47:0] destAddr = 0, node;
	logic [31:0] destCrc = 0, rs = 10889;
	logic [63:0] hash;
	logic [191:0] blk = 0;
	logic expV[$];
	logic [15:0] expR[$];
	int n_fail = 0, compares = 0;
	always #12.5 core_clk = ~core_clk;
	ibaf_filter i_ibaf_filter (.core_clk(core_clk), .rst_n(rst_n), .bus(bus), .regRdata(regRdata),
		.initBlockBase(base), .memReq(memReq), .memAddr(memAddr), .memAck(memAck), .memData(memData),
		.destValid(destValid), .destAddr(destAddr), .destCrc(destCrc), .frameAccept(fa),
		.frameReject(fr), .modeControl(modeControl), .rxRingBase(rxB), .txRingBase(txB),
		.initDone(initDone));
	ibaf_mem_model i_ibaf_mem_model (.core_clk(core_clk), .rst_n(rst_n), .memReq(memReq), .slow(slow),
		.memAddr(memAddr), .base(base), .blk(blk), .memAck(memAck), .memData(memData));
	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction : rnd
	task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
		compares++;
		if (e !== g) begin
			n_fail++;
			$display("FAIL %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic op(logic [3:0] a, logic [15:0] d, logic w);
		@(posedge core_clk);
		bus <= '{a, d, w, !w};
		if (!w) expR.push_back(d);
		@(posedge core_clk);
		bus <= '0;
	endtask : op
	task automatic dst(logic [47:0] a);
		@(posedge core_clk);
		destValid <= 1'b1;
		destAddr <= a;
		destCrc <= rnd();
		@(posedge core_clk);
		destValid <= 1'b0;
		expV.push_back(&a ? !mode[14] || mode[15] : mode[15] ? 1'b1 :
			a[0] ? hash[destCrc[31:26]] : a === node);
	endtask : dst
	task automatic init(logic [63:0] h, logic s);
		hash = h;
		slow = s;
		mode = 16'h4000;
		node = {rnd(), rnd()} & 48'hfffffffffffe;
		base = rnd() & 24'hfffffe;
		// Receive length code 7 (128 entries), transmit code 0 (one entry)
		blk = {16'(rnd() & 32'h00ff), 16'(rnd()), 16'he000 | 16'(rnd() & 32'h00ff),
			16'(rnd() & 32'hfff8), hash, node, mode};
		op(4'h4, 16'h0001, 1);
		for (int k = 0; k < 12; ) begin
			@(posedge core_clk);
			if (memAck) k++;
		end
		repeat (2) @(posedge core_clk);
		chk("mode", mode, modeControl);
		chk("bases", {blk[183:160], blk[151:128]}, {txB, rxB});
		$display("test init done");
	endtask : init
	task automatic give_verdict();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	always @(posedge core_clk) begin
		rdSeen <= bus.rd;
		if (rdSeen) chk("regRdata", expR.pop_front(), regRdata);
		if (fa || fr) chk("accept", expV.pop_front(), fa);
	end
	initial begin
		repeat (4000) @(posedge core_clk);
		n_fail++;
		give_verdict();
	end
	initial begin
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 4; i++) op(i, i == 1 || i == 2, 0);
		op(4'h9, 16'h0000, 0);
		op(4'h1, 16'h0005, 1);
		op(4'h1, 16'h0001, 0);
		init({rnd(), rnd()}, 1);
		op(4'h1, 16'h0080, 0);
		op(4'h2, 16'h0001, 0);
		for (int i = 0; i < 30; i++) dst(i % 3 == 0 ? node : {rnd(), rnd()} | (i % 3 == 2));
		for (int m = 0; m < 4; m++) begin
			mode = m << 14;
			op(4'h0, mode, 1);
			dst('1);
			dst({rnd(), rnd()} | 1);
		end
		op(4'h1, 16'h0005, 1);
		op(4'h1, 16'h0005, 0);
		init(0, 0);
		for (int i = 0; i < 4; i++) dst({rnd(), rnd()} | 1);
		$display("test filter done");
		give_verdict();
	end
endmodule : ibaf_filter_tb
`default_nettype wire

/* ibaf_mem_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ibaf_mem_model (
	input  wire logic         core_clk, rst_n, memReq, slow,
	input  wire logic [23:0]  memAddr, base,
	input  wire logic [191:0] blk,
	output logic              memAck,
	output logic [15:0]       memData
);
	logic [1:0] waitQ;
	always @(posedge core_clk) begin
		memAck <= 1'b0;
		memData <= ~memData; // Released bus must not keep showing the last word
		waitQ <= 2'h0;
		if (!rst_n) memData <= 16'h0000;
		else if (memReq && !memAck && waitQ < {slow, slow}) waitQ <= waitQ + 2'h1;
		else if (memReq && !memAck) begin
			memAck <= 1'b1;
			memData <= blk[(memAddr - base) * 8 +: 16];
		end
	end
endmodule : ibaf_mem_model
`default_nettype wire

/* ibaf_pkg.sv */
// Overview of operation
// (R1) Host aligns init block on 16-bit word
// (R2) Fetch twelve words in documented order
// (R3) Ring length codes in bits 15:13
// (R4) Length code n gives 2**n entries
// (R5) Software may rewrite ring counts afterward
// (R6) Host aligns ring entries on 8 bytes
// (R7) First wire bit one means logical address
// (R8) Top six CRC bits index hash mask
// (R9) Hash mask serves logical acceptance only
// (R10) Zero mask rejects logical except broadcast
// (R11) Broadcast bypasses mask, disable and promiscuous; code rejects broadcast when DRCVBC is set and PROM is clear
// (R12) Loopback multicast gives FCS to receiver
// (R13) Node address 48 bits, bit zero first
// (R14) First wire byte maps to bits 7:0
// (R15) Mode word copied into mode control
`default_nettype none
package ibaf_pkg;
	localparam logic [4:0]  WORD_MODE    = 5'h00;
	localparam logic [4:0]  WORD_NODE0   = 5'h02;
	localparam logic [4:0]  WORD_HASH0   = 5'h08;
	localparam logic [4:0]  WORD_RXLO    = 5'h10;
	localparam logic [4:0]  WORD_RXHI    = 5'h12;
	localparam logic [4:0]  WORD_TXLO    = 5'h14;
	localparam logic [4:0]  WORD_TXHI    = 5'h16;
	localparam logic [4:0]  WORD_LAST    = 5'h16;
	localparam int          LEN_MSB      = 15;
	localparam int          LEN_LSB      = 13;
	localparam int          MODE_PROM    = 15;
	localparam int          MODE_DRCVBC  = 14;
	localparam logic [3:0]  REG_MODE     = 4'h0;
	localparam logic [3:0]  REG_RXCNT    = 4'h1;
	localparam logic [3:0]  REG_TXCNT    = 4'h2;
	localparam logic [3:0]  REG_STATUS   = 4'h3;
	localparam logic [3:0]  REG_CTRL     = 4'h4;
	localparam logic [15:0] MODE_RESET   = 16'h0000;
	localparam logic [15:0] COUNT_RESET  = 16'h0001;

	typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_WAIT} ibaf_state_t;

	typedef struct packed {
		logic [3:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} ibaf_bus_t;

	typedef struct packed {
		ibaf_state_t state;
		logic [4:0]  offset;
		logic [15:0] mode;
		logic [47:0] node;
		logic [63:0] hash;
		logic [23:0] rxBase;
		logic [23:0] txBase;
		logic [15:0] rxCount;
		logic [15:0] txCount;
		logic        initDone;
		logic        memReq;
		logic [23:0] memAddr;
		logic [15:0] rdata;
		logic        accept;
		logic        reject;
	} ibaf_state_all_t;
endpackage : ibaf_pkg
`default_nettype wire
